//--- logic/soc_access_pkg.sv
// Constants, address map and carrier types for the register access and strap block
package soc_access_pkg;

  localparam int unsigned NUM_BLOCKS   = 45;
  localparam int unsigned BLK_IDX_W    = 6;
  localparam int unsigned NUM_GPIO     = 8;
  localparam int unsigned NUM_ROUTE    = 4;
  localparam int unsigned NUM_BATOUT   = 2;
  localparam int unsigned NUM_FLAGS    = 6;
  localparam int unsigned TRACE_W      = 4;

  // Block base addresses, in map order
  localparam logic [31:0] BLOCK_BASE [NUM_BLOCKS] = '{
    32'h4000_0400, 32'h4000_0C00, 32'h4000_0C20, 32'h4000_0C80, 32'h4000_0CA0,
    32'h4000_1000, 32'h4000_2400, 32'h4000_4000, 32'h4000_4400, 32'h4000_4800,
    32'h4000_4C00, 32'h4000_5000, 32'h4000_5100, 32'h4000_5200, 32'h4000_5300,
    32'h4007_0000, 32'h4000_5800, 32'h4000_5820, 32'h4000_5830, 32'h4000_5850,
    32'h4000_5860, 32'h4000_5870, 32'h4000_6000, 32'h4000_6010, 32'h4000_7400,
    32'h4000_7C00, 32'h4000_8C00, 32'h4000_9800, 32'h4000_9820, 32'h4000_A400,
    32'h4000_A800, 32'h4000_AC80, 32'h4000_AE00, 32'h4000_B800, 32'h4000_B900,
    32'h4000_E000, 32'h4000_FC00, 32'h4008_0000, 32'h4008_0100, 32'h4008_1000,
    32'h400F_2400, 32'h400F_2800, 32'h400F_2C00, 32'h400F_5000, 32'h400F_FF00
  };
  localparam logic [BLK_IDX_W-1:0] EC_SUB_IDX = 6'h24;
  localparam logic [31:0] BLOCK_SPAN  = 32'h0000_0010;
  localparam logic [31:0] EC_SUB_SPAN = 32'h0000_0100;

  // Subsystem bank offsets
  localparam logic [7:0] OFF_TRACE  = 8'h00;
  localparam logic [7:0] OFF_STRAP  = 8'h04;
  localparam logic [7:0] OFF_FLAGS  = 8'h08;
  localparam logic [7:0] OFF_KEY    = 8'h0C;
  localparam logic [7:0] OFF_ROUTE  = 8'h10;
  localparam logic [7:0] OFF_BATOUT = 8'h14;
  localparam logic [7:0] OFF_GPIO   = 8'h18;

  // Flag field positions
  localparam int unsigned FL_W1C = 0;
  localparam int unsigned FL_W0C = 1;
  localparam int unsigned FL_RC  = 2;
  localparam int unsigned FL_RS  = 3;
  localparam int unsigned FL_W1S = 4;
  localparam int unsigned FL_W0S = 5;

  // Field positions in the routing and gpio words
  localparam int unsigned ROUTE_ALT_LSB = 4;
  localparam int unsigned GPIO_OE_LSB   = 8;

  // Reset values
  localparam logic [NUM_FLAGS-1:0]  FLAGS_RST  = 6'h00;
  localparam logic [NUM_GPIO-1:0]   GPIO_RST   = 8'h00;
  localparam logic [NUM_BATOUT-1:0] BATOUT_RST = 2'h0;
  localparam logic [31:0]           KEY_RST    = 32'h0000_0000;

  // Strap capture: sync depth plus one sample
  localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic                 hit;
    logic [BLK_IDX_W-1:0] idx;
    logic [31:0]          off;
  } blk_hit_s;

endpackage

//--- logic/soc_register_access_and_straps.sv
// Register access fabric, subsystem bank, pin defaults and reset straps
// Functional notes
// - A signal's primary and alternate pin are never both selected.
// - Tap strap 1 routes debug port to boundary scan, 0 to processor.
// - Rail strap 1 selects 3.3V flash rail, 0 selects 1.8V.
// - Reserved locations and bits read zero; writes change nothing.
// - Read-only fields ignore writes.
// - Write-only fields read back as zero.
// - Read-to-set field becomes one when read.
// - Read-to-clear field returns value then clears; writes ignored.
// - Writing one clears a write-one-to-clear field; zero leaves it.
// - Writing zero clears a write-zero-to-clear field; one leaves it.
// - Writing one sets a write-one-to-set field; zero leaves it.
// - Writing zero sets a write-zero-to-set field; one leaves it.
// - Processor reaches each block's registers at offsets from its base.
// - Debug access path reaches the same block map as the processor.
// - Trace port stays inactive until the trace enable bit is set.
// - General pins stay tristated through and after reset unless programmed.
// - Battery outputs drive zero on battery power-up, then retain through resets.
`timescale 1ns/1ps

module soc_register_access_and_straps (
  input  wire logic                                      clk_sys_i,
  input  wire logic                                      arst_n_i,
  input  wire logic                                      arst_bat_n_i,
  input  wire logic                                      proc_req_i,
  input  wire soc_access_pkg::bus_req_s                  proc_cmd_i,
  output logic                                           proc_ack_o,
  output logic [31:0]                                    proc_rdata_o,
  input  wire logic                                      dbg_req_i,
  input  wire soc_access_pkg::bus_req_s                  dbg_cmd_i,
  output logic                                           dbg_ack_o,
  output logic [31:0]                                    dbg_rdata_o,
  output logic                                           blk_req_o,
  output logic                                           blk_we_o,
  output logic [soc_access_pkg::BLK_IDX_W-1:0]           blk_idx_o,
  output logic [31:0]                                    blk_off_o,
  output logic [31:0]                                    blk_wdata_o,
  input  wire logic [31:0]                               blk_rdata_i,
  input  wire logic [soc_access_pkg::NUM_FLAGS-1:0]      evt_set_i,
  input  wire logic [soc_access_pkg::NUM_FLAGS-1:0]      evt_clr_i,
  input  wire logic                                      tap_strap_pin_i,
  input  wire logic                                      rail_strap_pin_i,
  output logic                                           tap_to_bscan_o,
  output logic                                           flash_rail_strap_o,
  output logic                                           strap_valid_o,
  input  wire logic [soc_access_pkg::TRACE_W-1:0]        trace_data_i,
  output logic [soc_access_pkg::TRACE_W-1:0]             trace_data_o,
  output logic                                           trace_active_o,
  output logic [soc_access_pkg::NUM_ROUTE-1:0]           route_prim_sel_o,
  output logic [soc_access_pkg::NUM_ROUTE-1:0]           route_alt_sel_o,
  output logic [soc_access_pkg::NUM_GPIO-1:0]            general_purpose_pin_o,
  output logic [soc_access_pkg::NUM_GPIO-1:0]            general_purpose_pin_oe_o,
  output logic [soc_access_pkg::NUM_BATOUT-1:0]          battery_output_pin_o,
  output logic [31:0]                                    key_o
);

  function automatic soc_access_pkg::blk_hit_s blk_lookup(input logic [31:0] addr);
    soc_access_pkg::blk_hit_s res;
    logic [31:0]              span;
    res = '0;
    for (int i = 0; i < soc_access_pkg::NUM_BLOCKS; i++) begin
      span = (i == int'(soc_access_pkg::EC_SUB_IDX)) ? soc_access_pkg::EC_SUB_SPAN : soc_access_pkg::BLOCK_SPAN;
      if (!res.hit && addr >= soc_access_pkg::BLOCK_BASE[i] && addr - soc_access_pkg::BLOCK_BASE[i] < span) begin
        res.hit = 1'b1;
        res.idx = soc_access_pkg::BLK_IDX_W'(i);
        res.off = addr - soc_access_pkg::BLOCK_BASE[i];
      end
    end
    return res;
  endfunction

  // Arbitration: processor first, debug path otherwise
  logic                          take_proc;
  logic                          take_dbg;
  logic                          acc_valid;
  soc_access_pkg::bus_req_s      acc;
  soc_access_pkg::blk_hit_s      hit;
  logic                          own_bank;
  logic                          own_wr;
  logic                          own_rd;
  logic [7:0]                    own_off;
  logic [31:0]                   own_rdata;
  logic [31:0]                   next_rdata;

  assign take_proc = proc_req_i && !proc_ack_o;
  assign take_dbg  = dbg_req_i && !dbg_ack_o && !take_proc;
  assign acc_valid = take_proc || take_dbg;
  assign acc       = take_proc ? proc_cmd_i : dbg_cmd_i;
  assign hit       = blk_lookup(acc.addr);
  assign own_bank  = hit.hit && hit.idx == soc_access_pkg::EC_SUB_IDX;
  assign own_off   = hit.off[7:0];
  assign own_wr    = acc_valid && own_bank && acc.we;
  assign own_rd    = acc_valid && own_bank && !acc.we;

  // Forwarding strobe toward block registers; answer sampled same cycle
  assign blk_req_o   = acc_valid && hit.hit && !own_bank;
  assign blk_we_o    = acc.we;
  assign blk_idx_o   = hit.idx;
  assign blk_off_o   = hit.off;
  assign blk_wdata_o = acc.wdata;

  // Subsystem bank state
  logic                                  trace_en;
  logic [soc_access_pkg::NUM_FLAGS-1:0]  flags;
  logic [soc_access_pkg::NUM_FLAGS-1:0]  next_flags;
  logic [soc_access_pkg::NUM_ROUTE-1:0]  route_en;
  logic [soc_access_pkg::NUM_ROUTE-1:0]  route_alt;
  logic [soc_access_pkg::NUM_GPIO-1:0]   gpio_out;
  logic [soc_access_pkg::NUM_GPIO-1:0]   gpio_oe;
  logic [soc_access_pkg::NUM_BATOUT-1:0] bat_out;
  logic [31:0]                           key;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trace_en <= 1'b0;
    end else if (own_wr && own_off == soc_access_pkg::OFF_TRACE) begin
      trace_en <= acc.wdata[0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      route_en  <= '0;
      route_alt <= '0;
    end else if (own_wr && own_off == soc_access_pkg::OFF_ROUTE) begin
      route_en  <= acc.wdata[soc_access_pkg::NUM_ROUTE-1:0];
      route_alt <= acc.wdata[soc_access_pkg::ROUTE_ALT_LSB +: soc_access_pkg::NUM_ROUTE];
    end
  end

  // One select bit decides primary or alternate
  assign route_prim_sel_o = route_en & ~route_alt;
  assign route_alt_sel_o  = route_en & route_alt;

  // Pins come out of reset undriven
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gpio_out <= soc_access_pkg::GPIO_RST;
      gpio_oe  <= soc_access_pkg::GPIO_RST;
    end else if (own_wr && own_off == soc_access_pkg::OFF_GPIO) begin
      gpio_out <= acc.wdata[soc_access_pkg::NUM_GPIO-1:0];
      gpio_oe  <= acc.wdata[soc_access_pkg::GPIO_OE_LSB +: soc_access_pkg::NUM_GPIO];
    end
  end
  assign general_purpose_pin_o    = gpio_out;
  assign general_purpose_pin_oe_o = gpio_oe;

  // Battery reset only; system reset does not touch it
  always_ff @(posedge clk_sys_i or negedge arst_bat_n_i) begin
    if (!arst_bat_n_i) begin
      bat_out <= soc_access_pkg::BATOUT_RST;
    end else if (arst_n_i && own_wr && own_off == soc_access_pkg::OFF_BATOUT) begin
      bat_out <= acc.wdata[soc_access_pkg::NUM_BATOUT-1:0];
    end
  end
  assign battery_output_pin_o = bat_out;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key <= soc_access_pkg::KEY_RST;
    end else if (own_wr && own_off == soc_access_pkg::OFF_KEY) begin
      key <= acc.wdata;
    end
  end
  assign key_o = key;

  // Flag fields: software effect first, hardware set wins over clear
  logic flag_wr;
  logic flag_rd;
  assign flag_wr = own_wr && own_off == soc_access_pkg::OFF_FLAGS;
  assign flag_rd = own_rd && own_off == soc_access_pkg::OFF_FLAGS;

  always_comb begin
    next_flags = flags;
    if (flag_wr) begin
      if (acc.wdata[soc_access_pkg::FL_W1C]) next_flags[soc_access_pkg::FL_W1C] = 1'b0;
      if (!acc.wdata[soc_access_pkg::FL_W0C]) next_flags[soc_access_pkg::FL_W0C] = 1'b0;
      if (acc.wdata[soc_access_pkg::FL_W1S]) next_flags[soc_access_pkg::FL_W1S] = 1'b1;
      if (!acc.wdata[soc_access_pkg::FL_W0S]) next_flags[soc_access_pkg::FL_W0S] = 1'b1;
    end
    if (flag_rd) begin
      next_flags[soc_access_pkg::FL_RC] = 1'b0;
      next_flags[soc_access_pkg::FL_RS] = 1'b1;
    end
    next_flags = next_flags & ~evt_clr_i;
    next_flags = next_flags | evt_set_i;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags <= soc_access_pkg::FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // Strap synchroniser and one-time capture
  logic       tap_s1;
  logic       tap_s2;
  logic       rail_s1;
  logic       rail_s2;
  logic [1:0] strap_cnt;
  logic       strap_done;
  logic       tap_sel;
  logic       rail_sel;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tap_s1  <= 1'b0;
      tap_s2  <= 1'b0;
      rail_s1 <= 1'b0;
      rail_s2 <= 1'b0;
    end else begin
      tap_s1  <= tap_strap_pin_i;
      tap_s2  <= tap_s1;
      rail_s1 <= rail_strap_pin_i;
      rail_s2 <= rail_s1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      tap_sel    <= 1'b0;
      rail_sel   <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == soc_access_pkg::STRAP_CAPTURE_CNT) begin
        strap_done <= 1'b1;
        tap_sel    <= tap_s2;
        rail_sel   <= rail_s2;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  assign tap_to_bscan_o     = tap_sel;
  assign flash_rail_strap_o = rail_sel;
  assign strap_valid_o      = strap_done;

  assign trace_active_o = trace_en;
  assign trace_data_o   = trace_en ? trace_data_i : '0;

  always_comb begin
    own_rdata = 32'h0000_0000;
    unique case (own_off)
      soc_access_pkg::OFF_TRACE:  own_rdata[0] = trace_en;
      soc_access_pkg::OFF_STRAP:  own_rdata[1:0] = {rail_sel, tap_sel};
      soc_access_pkg::OFF_FLAGS:  own_rdata[soc_access_pkg::NUM_FLAGS-1:0] = flags;
      soc_access_pkg::OFF_ROUTE:  own_rdata[7:0] = {route_alt, route_en};
      soc_access_pkg::OFF_BATOUT: own_rdata[soc_access_pkg::NUM_BATOUT-1:0] = bat_out;
      soc_access_pkg::OFF_GPIO:   own_rdata[15:0] = {gpio_oe, gpio_out};
      default:                    own_rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (!acc.we && hit.hit) begin
      next_rdata = own_bank ? own_rdata : blk_rdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      proc_ack_o   <= 1'b0;
      dbg_ack_o    <= 1'b0;
      proc_rdata_o <= 32'h0000_0000;
      dbg_rdata_o  <= 32'h0000_0000;
    end else begin
      proc_ack_o <= take_proc;
      dbg_ack_o  <= take_dbg;
      if (take_proc) proc_rdata_o <= next_rdata;
      if (take_dbg) dbg_rdata_o <= next_rdata;
    end
  end

  // Helper: answer kind of the last taken access
  logic last_unmapped;
  logic last_wo_rd;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_unmapped <= 1'b0;
      last_wo_rd    <= 1'b0;
    end else begin
      last_unmapped <= acc_valid && !hit.hit;
      last_wo_rd    <= own_rd && own_off == soc_access_pkg::OFF_KEY;
    end
  end

  property p_route_excl;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (route_prim_sel_o & route_alt_sel_o) == '0;
  endproperty
  a_route_excl: assert property (p_route_excl) else $error("primary and alternate both selected");

  property p_tap_capture;
    @(posedge clk_sys_i) disable iff (!arst_n_i) $rose(strap_done) |-> tap_to_bscan_o == $past(tap_s2);
  endproperty
  a_tap_capture: assert property (p_tap_capture) else $error("tap strap not captured");

  property p_strap_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i) strap_done |=> $stable(flash_rail_strap_o) && $stable(tap_to_bscan_o);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

  property p_unmapped_zero;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      last_unmapped |-> (proc_ack_o ? proc_rdata_o : dbg_rdata_o) == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_wo_zero;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      last_wo_rd |-> (proc_ack_o ? proc_rdata_o : dbg_rdata_o) == 32'h0000_0000;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only read not zero");

  property p_rc_clear;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      flag_rd && !evt_set_i[soc_access_pkg::FL_RC] |=> !flags[soc_access_pkg::FL_RC];
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("read-to-clear did not clear");

  property p_rs_set;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      flag_rd && !evt_clr_i[soc_access_pkg::FL_RS] |=> flags[soc_access_pkg::FL_RS];
  endproperty
  a_rs_set: assert property (p_rs_set) else $error("read-to-set did not set");

  property p_w1c;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      flag_wr && !evt_set_i[soc_access_pkg::FL_W1C] |=>
        flags[soc_access_pkg::FL_W1C] == ($past(flags[soc_access_pkg::FL_W1C]) & ~$past(acc.wdata[0]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-to-clear wrong");

  property p_w0s;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      flag_wr && !acc.wdata[soc_access_pkg::FL_W0S] && !evt_clr_i[soc_access_pkg::FL_W0S]
        |=> flags[soc_access_pkg::FL_W0S];
  endproperty
  a_w0s: assert property (p_w0s) else $error("write-zero-to-set did not set");

  property p_trace_off;
    @(posedge clk_sys_i) disable iff (!arst_n_i) !trace_active_o |-> trace_data_o == '0;
  endproperty
  a_trace_off: assert property (p_trace_off) else $error("trace active while disabled");

  property p_gpio_tristate;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $changed(general_purpose_pin_oe_o) |-> $past(own_wr) && $past(own_off) == soc_access_pkg::OFF_GPIO;
  endproperty
  a_gpio_tristate: assert property (p_gpio_tristate) else $error("pin enable changed unprogrammed");

endmodule

//--- bench/blk_model.sv
// Mapped block responder that answers with an address-derived word
`timescale 1ns/1ps
module blk_model (
  input  wire logic                                clk_sys_i,
  input  wire logic                                blk_req_i,
  input  wire logic [soc_access_pkg::BLK_IDX_W-1:0] blk_idx_i,
  input  wire logic [31:0]                         blk_off_i,
  output logic [31:0]                              blk_rdata_o,
  output int                                       strobes_o
);
  logic [31:0] noise;
  initial begin
    noise = 32'h0000_0000;
    strobes_o = 0;
  end
  // Idle bus toggles so stale data never matches
  always @(posedge clk_sys_i) begin
    noise <= ~noise;
    if (blk_req_i === 1'b1) strobes_o <= strobes_o + 1;
  end
  assign blk_rdata_o = (blk_req_i === 1'b1) ? {2'h0, blk_idx_i, blk_off_i[23:0]} : (noise ^ 32'h5A5A_5A5A);
endmodule

//--- bench/soc_register_access_and_straps_test.sv
// Self-checking bench for register access, pin defaults and straps
`timescale 1ns/1ps
module soc_register_access_and_straps_test;
  localparam logic [31:0] SUB = soc_access_pkg::BLOCK_BASE[soc_access_pkg::EC_SUB_IDX];
  logic clk_sys_i, arst_n_i, arst_bat_n_i, proc_req, dbg_req, tap_pin, rail_pin, tap_o, rail_o, valid_o;
  logic proc_ack, dbg_ack, blk_req, blk_we, trace_act;
  soc_access_pkg::bus_req_s cmd;
  logic [31:0] proc_rd, dbg_rd, blk_off, blk_wd, blk_rd, key;
  logic [5:0] blk_idx, evt_set, evt_clr;
  logic [3:0] trace_in, trace_out, prim, alt;
  logic [7:0] gp, gp_oe;
  logic [1:0] bat;
  int num_errors, tests_run, strobes;

  soc_register_access_and_straps soc_register_access_and_straps_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .arst_bat_n_i(arst_bat_n_i),
    .proc_req_i(proc_req), .proc_cmd_i(cmd), .proc_ack_o(proc_ack), .proc_rdata_o(proc_rd),
    .dbg_req_i(dbg_req), .dbg_cmd_i(cmd), .dbg_ack_o(dbg_ack), .dbg_rdata_o(dbg_rd),
    .blk_req_o(blk_req), .blk_we_o(blk_we), .blk_idx_o(blk_idx), .blk_off_o(blk_off),
    .blk_wdata_o(blk_wd), .blk_rdata_i(blk_rd), .evt_set_i(evt_set), .evt_clr_i(evt_clr),
    .tap_strap_pin_i(tap_pin), .rail_strap_pin_i(rail_pin), .tap_to_bscan_o(tap_o),
    .flash_rail_strap_o(rail_o), .strap_valid_o(valid_o), .trace_data_i(trace_in),
    .trace_data_o(trace_out), .trace_active_o(trace_act), .route_prim_sel_o(prim),
    .route_alt_sel_o(alt), .general_purpose_pin_o(gp), .general_purpose_pin_oe_o(gp_oe),
    .battery_output_pin_o(bat), .key_o(key));

  blk_model blk_model_inst (.clk_sys_i(clk_sys_i), .blk_req_i(blk_req), .blk_idx_i(blk_idx),
    .blk_off_i(blk_off), .blk_rdata_o(blk_rd), .strobes_o(strobes));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One word transfer; request held until ack is sampled high
  task automatic acc(input logic d, input logic we, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clk_sys_i);
    #1;
    cmd = '{we: we, addr: a, wdata: wd};
    if (d) dbg_req = 1'b1;
    else proc_req = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (((d ? dbg_ack : proc_ack) !== 1'b1) && n < 20);
    if (n >= 20) begin
      num_errors++;
      give_verdict();
    end
    rd = d ? dbg_rd : proc_rd;
    proc_req = 1'b0;
    dbg_req = 1'b0;
  endtask

  task automatic pulse(input logic [5:0] s, input logic [5:0] c);
    @(posedge clk_sys_i);
    #1;
    evt_set = s;
    evt_clr = c;
    @(posedge clk_sys_i);
    #1;
    evt_set = 6'h00;
    evt_clr = 6'h00;
  endtask

  // Reset with given strap levels, then move the pins and expect no change
  task automatic t_straps(input logic tp, input logic rp, input logic [1:0] bat_exp);
    @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b0;
    tap_pin = tp;
    rail_pin = rp;
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk("oe in reset", 32'h0, {24'h0, gp_oe});
    chk("route in reset", 32'h0, {24'h0, prim, alt});
    chk("trace in reset", 32'h0, {27'h0, trace_act, trace_out});
    chk("battery in reset", {30'h0, bat_exp}, {30'h0, bat});
    arst_n_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("valid early", 32'h0, {31'h0, valid_o});
    @(posedge clk_sys_i);
    #1;
    chk("valid", 32'h1, {31'h0, valid_o});
    chk("tap strap", {31'h0, tp}, {31'h0, tap_o});
    chk("rail strap", {31'h0, rp}, {31'h0, rail_o});
    tap_pin = ~tp;
    rail_pin = ~rp;
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk("straps held", {30'h1, rp, tp}, {30'h1, rail_o, tap_o});
    chk("oe after reset", 32'h0, {24'h0, gp_oe});
    $display("straps test done");
  endtask

  task automatic t_map();
    logic [31:0] r;
    int s;
    int ix[4] = '{0, 15, 38, 44};
    foreach (ix[k]) begin
      acc(k[0], 1'b0, soc_access_pkg::BLOCK_BASE[ix[k]] + 32'h4, 32'h0, r);
      chk("block read", {2'h0, ix[k][5:0], 24'h4}, r);
    end
    s = strobes;
    acc(1'b0, 1'b1, 32'h4000_0410, 32'hFFFF_FFFF, r);
    acc(1'b1, 1'b0, 32'h4000_0410, 32'h0, r);
    chk("unmapped read", 32'h0, r);
    chk("unmapped strobes", s, strobes);
    $display("map test done");
  endtask

  task automatic t_access();
    logic [31:0] r;
    logic [7:0] v[3] = '{8'h0F, 8'hF5, 8'hFF};
    chk("trace off", 32'h0, {27'h0, trace_act, trace_out});
    acc(1'b0, 1'b1, SUB, 32'hFFFF_FFFF, r);
    acc(1'b0, 1'b0, SUB, 32'h0, r);
    chk("trace reg", 32'h1, r);
    chk("trace on", {27'h1, trace_in}, {27'h0, trace_act, trace_out});
    acc(1'b1, 1'b1, SUB + 32'h4, 32'h0, r);
    acc(1'b1, 1'b0, SUB + 32'h4, 32'h0, r);
    chk("strap reg", {30'h0, rail_o, tap_o}, r);
    acc(1'b0, 1'b1, SUB + 32'hC, 32'h1234_5678, r);
    acc(1'b0, 1'b0, SUB + 32'hC, 32'h0, r);
    chk("key read", 32'h0, r);
    chk("key value", 32'h1234_5678, key);
    // Only reserved space is disturbed, never a test location
    acc(1'b0, 1'b1, SUB + 32'h40, 32'hFFFF_FFFF, r);
    acc(1'b0, 1'b0, SUB + 32'h40, 32'h0, r);
    chk("reserved read", 32'h0, r);
    foreach (v[k]) begin
      acc(1'b0, 1'b1, SUB + 32'h10, {24'h0, v[k]}, r);
      chk("route alt", {28'h0, v[k][3:0] & v[k][7:4]}, {28'h0, alt});
      chk("route overlap", 32'h0, {28'h0, prim & alt});
    end
    acc(1'b0, 1'b1, SUB + 32'h18, 32'h0000_C3A5, r);
    chk("gpio", 32'hC3A5, {16'h0, gp_oe, gp});
    acc(1'b0, 1'b1, SUB + 32'h14, 32'h3, r);
    chk("battery", 32'h3, {30'h0, bat});
    $display("access test done");
  endtask

  task automatic t_flags();
    logic [31:0] r;
    pulse(6'h3F, 6'h00);
    pulse(6'h00, 6'h38);
    acc(1'b0, 1'b1, SUB + 32'h8, 32'h22, r);
    acc(1'b0, 1'b0, SUB + 32'h8, 32'h0, r);
    chk("flags a", 32'h07, r);
    acc(1'b1, 1'b0, SUB + 32'h8, 32'h0, r);
    chk("flags b", 32'h0B, r);
    pulse(6'h00, 6'h08);
    acc(1'b0, 1'b1, SUB + 32'h8, 32'h01, r);
    acc(1'b0, 1'b0, SUB + 32'h8, 32'h0, r);
    chk("flags c", 32'h20, r);
    pulse(6'h00, 6'h28);
    acc(1'b1, 1'b1, SUB + 32'h8, 32'h30, r);
    acc(1'b1, 1'b0, SUB + 32'h8, 32'h0, r);
    chk("flags d", 32'h10, r);
    $display("flags test done");
  endtask

  initial begin
    arst_n_i = 1'b0;
    arst_bat_n_i = 1'b0;
    proc_req = 1'b0;
    dbg_req = 1'b0;
    cmd = '0;
    evt_set = 6'h00;
    evt_clr = 6'h00;
    tap_pin = 1'b1;
    rail_pin = 1'b0;
    trace_in = 4'hA;
    #230 arst_bat_n_i = 1'b1;
    t_straps(1'b1, 1'b0, 2'h0);
    t_map();
    t_access();
    t_flags();
    trace_in = 4'h5;
    t_straps(1'b0, 1'b1, 2'h3);
    give_verdict();
  end
endmodule
